// >>> hdl/tmw_timer8.sv
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - One clock; tick is a clock enable
// - Counter advances only on prescaled tick
// - Nonzero action field takes pin; direction enables
// - Channel A non-PWM: off, toggle, clear, set
// - Channel B non-PWM: same encoding
// - Fast PWM A: toggle if top bit, clear/set
// - Fast PWM B: 01 reserved, clear/set at TOP
// - Phase-correct A: toggle option, up/down actions
// - Phase-correct B: 01 reserved, up/down actions
// - Compare equals TOP: act at TOP only
// - Wave mode decode with reserved 4, 6
// - Compare updates immediate or at TOP
// - Overflow flag at MAX, BOTTOM or TOP
// - Match A clears counter next tick
// - Control A bits 3:2 read zero
// - Clock select: stop, divides, external edges
// - Force compare acts silently, reads zero
module tmw_timer8
  import tmw_pkg::*;
(
  // Clock, reset, enable
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // External count pin
  input wire logic EXT_CLK_PIN_IN,
  // Compare pins and interrupt
  output logic COMPARE_OUT_A_OUT,
  output logic COMPARE_OE_A_OUT,
  output logic COMPARE_OUT_B_OUT,
  output logic COMPARE_OE_B_OUT,
  output logic IRQ_OUT
);

  tmw_state_t st_r;
  tmw_state_t st_nxt;

  // New pin level after a compare action: toggle, else the set level
  function automatic logic act_level(input logic [1:0] code, input logic cur, input logic up);
    unique case (code)
      2'b01: act_level = ~cur;
      2'b10: act_level = up;
      default: act_level = up;
    endcase
  endfunction

  logic [7:0] wdata8;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  tmw_wave_mode_t wm;
  tmw_clock_select_t cs;
  logic pwm_mode;
  logic fast_mode;
  logic pc_mode;
  logic top_oca;
  logic [7:0] top_val;
  logic tick;
  logic at_top;
  logic match_a;
  logic match_b;
  logic [1:0] act_a;
  logic [1:0] act_b;
  logic [31:0] rdata;

  // Bus decode
  always_comb begin
    wdata8 = PWDATA_IN[7:0];
    wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN;
    rd_en = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
    unique case (PADDR_IN)
      TMW_OFS_CTRL_A, TMW_OFS_CTRL_B, TMW_OFS_COUNT, TMW_OFS_CMP_A, TMW_OFS_CMP_B,
      TMW_OFS_IRQ_STAT, TMW_OFS_IRQ_EN, TMW_OFS_IRQ_CLR, TMW_OFS_PIN_DIR: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Mode decode
  always_comb begin
    wm = tmw_wave_mode_t'({st_r.ctrl_b[TMW_WAVE_TOP_BIT], st_r.ctrl_a[1:0]});
    cs = tmw_clock_select_t'(st_r.ctrl_b[2:0]);
    act_a = st_r.ctrl_a[TMW_ACT_A_HI:TMW_ACT_A_LO];
    act_b = st_r.ctrl_a[TMW_ACT_B_HI:TMW_ACT_B_LO];
    fast_mode = (wm == TMW_WM_FAST_FF) || (wm == TMW_WM_FAST_OCA);
    pc_mode = (wm == TMW_WM_PC_FF) || (wm == TMW_WM_PC_OCA);
    pwm_mode = fast_mode | pc_mode;
    top_oca = (wm == TMW_WM_CTC) || (wm == TMW_WM_PC_OCA) || (wm == TMW_WM_FAST_OCA);
    top_val = top_oca ? st_r.cmp_a : TMW_MAX;
    at_top = (st_r.count == top_val);
    match_a = (st_r.count == st_r.cmp_a) & ~st_r.block_match;
    match_b = (st_r.count == st_r.cmp_b) & ~st_r.block_match;
  end

  // Tick select from prescaler and external pin
  always_comb begin
    unique case (cs)
      TMW_CS_STOP: tick = 1'b0;
      TMW_CS_DIV1: tick = 1'b1;
      TMW_CS_DIV8: tick = (st_r.prescale[2:0] == TMW_DIV8_M[2:0]);
      TMW_CS_DIV64: tick = (st_r.prescale[5:0] == TMW_DIV64_M[5:0]);
      TMW_CS_DIV256: tick = (st_r.prescale[7:0] == TMW_DIV256_M[7:0]);
      TMW_CS_DIV1024: tick = (st_r.prescale == TMW_DIV1024_M);
      TMW_CS_EXT_FALL: tick = st_r.ext_sync[2] & ~st_r.ext_sync[1];
      TMW_CS_EXT_RISE: tick = ~st_r.ext_sync[2] & st_r.ext_sync[1];
    endcase
  end

  // Read mux
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (PADDR_IN)
      TMW_OFS_CTRL_A: rdata[7:0] = st_r.ctrl_a & TMW_CTRL_A_MASK;
      TMW_OFS_CTRL_B: rdata[7:0] = {4'h0, st_r.ctrl_b};
      TMW_OFS_COUNT: rdata[7:0] = st_r.count;
      TMW_OFS_CMP_A: rdata[7:0] = st_r.cmp_a_buf;
      TMW_OFS_CMP_B: rdata[7:0] = st_r.cmp_b_buf;
      TMW_OFS_IRQ_STAT: rdata[2:0] = st_r.irq_stat;
      TMW_OFS_IRQ_EN: rdata[2:0] = st_r.irq_en;
      TMW_OFS_PIN_DIR: rdata[1:0] = st_r.pin_dir;
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp.pready = PSEL_IN & ~PENABLE_IN;
    st_nxt.rsp.pslverr = PSEL_IN & ~PENABLE_IN & ~addr_ok;
    st_nxt.rsp.prdata = (PSEL_IN & ~PENABLE_IN & ~PWRITE_IN) ? rdata : 32'h0000_0000;
    st_nxt.ext_sync = {st_r.ext_sync[1:0], EXT_CLK_PIN_IN};
    st_nxt.prescale = (cs == TMW_CS_STOP) ? st_r.prescale : st_r.prescale + 10'h001;

    // Count, waveform and flags on each tick
    if (tick) begin
      st_nxt.block_match = 1'b0;
      if (pc_mode) begin
        if (at_top) begin
          st_nxt.count_down = 1'b1;
          st_nxt.count = st_r.count - 8'h01;
        end else if (st_r.count_down && st_r.count == TMW_BOTTOM) begin
          st_nxt.count_down = 1'b0;
          st_nxt.count = st_r.count + 8'h01;
          st_nxt.irq_stat[TMW_ST_OVF] = 1'b1;
        end else begin
          st_nxt.count = st_r.count_down ? st_r.count - 8'h01 : st_r.count + 8'h01;
        end
      end else begin
        st_nxt.count_down = 1'b0;
        st_nxt.count = (top_oca && at_top) ? TMW_BOTTOM : st_r.count + 8'h01;
        if ((wm == TMW_WM_FAST_OCA) ? at_top : (st_r.count == TMW_MAX))
          st_nxt.irq_stat[TMW_ST_OVF] = 1'b1;
      end
      if (match_a)
        st_nxt.irq_stat[TMW_ST_MA] = 1'b1;
      if (match_b)
        st_nxt.irq_stat[TMW_ST_MB] = 1'b1;
      // Compare buffers load at TOP in PWM modes
      if (pwm_mode && at_top) begin
        st_nxt.cmp_a = st_r.cmp_a_buf;
        st_nxt.cmp_b = st_r.cmp_b_buf;
      end
      // Channel A and B waveforms
      if (!pwm_mode) begin
        if (match_a && act_a != 2'b00)
          st_nxt.cmp_out_a = act_level(act_a, st_r.cmp_out_a, act_a[0]);
        if (match_b && act_b != 2'b00)
          st_nxt.cmp_out_b = act_level(act_b, st_r.cmp_out_b, act_b[0]);
      end else if (fast_mode) begin
        if (act_a == 2'b01 && wm == TMW_WM_FAST_OCA && match_a)
          st_nxt.cmp_out_a = ~st_r.cmp_out_a;
        else if (act_a[1] && at_top)
          st_nxt.cmp_out_a = ~act_a[0];
        else if (act_a[1] && match_a)
          st_nxt.cmp_out_a = act_a[0];
        if (act_b[1] && at_top)
          st_nxt.cmp_out_b = ~act_b[0];
        else if (act_b[1] && match_b)
          st_nxt.cmp_out_b = act_b[0];
      end else begin
        if (act_a == 2'b01 && wm == TMW_WM_PC_OCA && match_a)
          st_nxt.cmp_out_a = ~st_r.cmp_out_a;
        else if (act_a[1] && st_r.cmp_a == top_val && at_top)
          st_nxt.cmp_out_a = ~act_a[0];
        else if (act_a[1] && match_a)
          st_nxt.cmp_out_a = act_a[0] ^ st_r.count_down;
        if (act_b[1] && st_r.cmp_b == top_val && at_top)
          st_nxt.cmp_out_b = ~act_b[0];
        else if (act_b[1] && match_b)
          st_nxt.cmp_out_b = act_b[0] ^ st_r.count_down;
      end
    end

    // Register writes, taken in the access phase
    if (wr_en) begin
      unique case (PADDR_IN)
        TMW_OFS_CTRL_A: st_nxt.ctrl_a = wdata8 & TMW_CTRL_A_MASK;
        TMW_OFS_CTRL_B: begin
          st_nxt.ctrl_b = wdata8[3:0] & TMW_CTRL_B_MASK[3:0];
          // Force strobes act only in non-PWM modes, no flag, no clear
          if (!pwm_mode && wdata8[TMW_FORCE_A_BIT] && act_a != 2'b00)
            st_nxt.cmp_out_a = act_level(act_a, st_r.cmp_out_a, act_a[0]);
          if (!pwm_mode && wdata8[TMW_FORCE_B_BIT] && act_b != 2'b00)
            st_nxt.cmp_out_b = act_level(act_b, st_r.cmp_out_b, act_b[0]);
        end
        TMW_OFS_COUNT: begin
          st_nxt.count = wdata8;
          st_nxt.block_match = 1'b1;
        end
        TMW_OFS_CMP_A: begin
          st_nxt.cmp_a_buf = wdata8;
          if (!pwm_mode)
            st_nxt.cmp_a = wdata8;
        end
        TMW_OFS_CMP_B: begin
          st_nxt.cmp_b_buf = wdata8;
          if (!pwm_mode)
            st_nxt.cmp_b = wdata8;
        end
        TMW_OFS_IRQ_EN: st_nxt.irq_en = wdata8[2:0];
        // Set wins over clear
        TMW_OFS_IRQ_CLR: st_nxt.irq_stat = st_nxt.irq_stat & ~(wdata8[2:0] & ~(st_nxt.irq_stat & ~st_r.irq_stat));
        TMW_OFS_PIN_DIR: st_nxt.pin_dir = wdata8[1:0];
        default: ;
      endcase
    end

    // Pin ownership and interrupt
    st_nxt.pins.out_a = st_nxt.cmp_out_a;
    st_nxt.pins.out_b = st_nxt.cmp_out_b;
    st_nxt.pins.oe_a = (st_nxt.ctrl_a[TMW_ACT_A_HI:TMW_ACT_A_LO] != 2'b00) & st_nxt.pin_dir[0];
    st_nxt.pins.oe_b = (st_nxt.ctrl_a[TMW_ACT_B_HI:TMW_ACT_B_LO] != 2'b00) & st_nxt.pin_dir[1];
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_en);
  end

  // State register
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_r <= '0;
      st_r.ctrl_a <= TMW_CTRL_A_RST;
      st_r.ctrl_b <= TMW_CTRL_B_RST[3:0];
    end else if (CE_IN) begin
      st_r <= st_nxt;
    end
  end

  // Ports straight from state
  always_comb begin
    PRDATA_OUT = st_r.rsp.prdata;
    PREADY_OUT = st_r.rsp.pready;
    PSLVERR_OUT = st_r.rsp.pslverr;
    COMPARE_OUT_A_OUT = st_r.pins.out_a;
    COMPARE_OE_A_OUT = st_r.pins.oe_a;
    COMPARE_OUT_B_OUT = st_r.pins.out_b;
    COMPARE_OE_B_OUT = st_r.pins.oe_b;
    IRQ_OUT = st_r.irq;
  end

endmodule // tmw_timer8

// >>> hdl/tmw_pkg.sv
package tmw_pkg;
  // Register byte addresses
  localparam logic [11:0] TMW_OFS_CTRL_A = 12'h000;
  localparam logic [11:0] TMW_OFS_CTRL_B = 12'h004;
  localparam logic [11:0] TMW_OFS_COUNT = 12'h008;
  localparam logic [11:0] TMW_OFS_CMP_A = 12'h00c;
  localparam logic [11:0] TMW_OFS_CMP_B = 12'h010;
  localparam logic [11:0] TMW_OFS_IRQ_STAT = 12'h014;
  localparam logic [11:0] TMW_OFS_IRQ_EN = 12'h018;
  localparam logic [11:0] TMW_OFS_IRQ_CLR = 12'h01c;
  localparam logic [11:0] TMW_OFS_PIN_DIR = 12'h020;
  // Reset values
  localparam logic [7:0] TMW_CTRL_A_RST = 8'h00;
  localparam logic [7:0] TMW_CTRL_B_RST = 8'h00;
  // Field positions
  localparam int TMW_ACT_A_HI = 7;
  localparam int TMW_ACT_A_LO = 6;
  localparam int TMW_ACT_B_HI = 5;
  localparam int TMW_ACT_B_LO = 4;
  localparam int TMW_FORCE_A_BIT = 7;
  localparam int TMW_FORCE_B_BIT = 6;
  localparam int TMW_WAVE_TOP_BIT = 3;
  // Writable masks: reserved bits read as zero
  localparam logic [7:0] TMW_CTRL_A_MASK = 8'hf3;
  localparam logic [7:0] TMW_CTRL_B_MASK = 8'h0f;
  // Status bit positions
  localparam int TMW_ST_OVF = 0;
  localparam int TMW_ST_MA = 1;
  localparam int TMW_ST_MB = 2;
  // Counter limits
  localparam logic [7:0] TMW_MAX = 8'hff;
  localparam logic [7:0] TMW_BOTTOM = 8'h00;
  // Prescaler tap points
  localparam int TMW_PRE_W = 10;
  localparam logic [9:0] TMW_DIV8_M = 10'h007;
  localparam logic [9:0] TMW_DIV64_M = 10'h03f;
  localparam logic [9:0] TMW_DIV256_M = 10'h0ff;
  localparam logic [9:0] TMW_DIV1024_M = 10'h3ff;

  typedef enum logic [2:0] {
    TMW_CS_STOP, TMW_CS_DIV1, TMW_CS_DIV8, TMW_CS_DIV64,
    TMW_CS_DIV256, TMW_CS_DIV1024, TMW_CS_EXT_FALL, TMW_CS_EXT_RISE
  } tmw_clock_select_t;

  typedef enum logic [2:0] {
    TMW_WM_NORMAL, TMW_WM_PC_FF, TMW_WM_CTC, TMW_WM_FAST_FF,
    TMW_WM_RES4, TMW_WM_PC_OCA, TMW_WM_RES6, TMW_WM_FAST_OCA
  } tmw_wave_mode_t;

  // Pin-side bundle
  typedef struct packed {
    logic out_a;
    logic oe_a;
    logic out_b;
    logic oe_b;
  } tmw_pins_t;

  // APB slave answer bundle
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tmw_apb_rsp_t;

  // All module state
  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [3:0] ctrl_b;
    logic [7:0] count;
    logic count_down;
    logic [7:0] cmp_a_buf;
    logic [7:0] cmp_b_buf;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [1:0] pin_dir;
    logic [9:0] prescale;
    logic [2:0] ext_sync;
    logic block_match;
    logic cmp_out_a;
    logic cmp_out_b;
    tmw_pins_t pins;
    logic irq;
    tmw_apb_rsp_t rsp;
  } tmw_state_t;
endpackage

// >>> dv/tmw_chk.sv
`timescale 1ns/1ps
module tmw_chk
  import tmw_pkg::*;
(
  // Watched ports
  input wire logic CLK_IN, RST_N_IN, CE_IN, PSEL_IN, PENABLE_IN, PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN, PRDATA_OUT,
  input wire logic PREADY_OUT, PSLVERR_OUT, EXT_CLK_PIN_IN, IRQ_OUT,
  input wire logic COMPARE_OUT_A_OUT, COMPARE_OE_A_OUT, COMPARE_OUT_B_OUT, COMPARE_OE_B_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic [7:0] act_r;
  logic [2:0] en_r;
  logic wr_ok;
  assign wr_ok = CE_IN && PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT && !PSLVERR_OUT;
  // Shadow of action fields and enables
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      act_r <= 8'h00;
      en_r <= 3'h0;
    end else if (wr_ok && PADDR_IN == TMW_OFS_CTRL_A) begin
      act_r <= PWDATA_IN[7:0];
    end else if (wr_ok && PADDR_IN == TMW_OFS_IRQ_EN) begin
      en_r <= PWDATA_IN[2:0];
    end
  end
  a_ready_next: assert property (PSEL_IN && !PENABLE_IN && CE_IN |=> PREADY_OUT)
    else $error("no answer after setup");
  a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT) else $error("ready too long");
  a_idle_rdata: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0) else $error("stray read data");
  a_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT) else $error("error without ready");
  a_rsv_zero: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN == TMW_OFS_CTRL_A |->
    PRDATA_OUT[3:2] == 2'b00) else $error("reserved bits nonzero");
  a_force_zero: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN == TMW_OFS_CTRL_B |->
    PRDATA_OUT[7:4] == 4'h0) else $error("force bits nonzero");
  a_oe_a_field: assert property (COMPARE_OE_A_OUT |-> act_r[7:6] != 0 || $past(act_r[7:6]) != 0)
    else $error("pin a driven while off");
  a_oe_b_field: assert property (COMPARE_OE_B_OUT |-> act_r[5:4] != 0 || $past(act_r[5:4]) != 0)
    else $error("pin b driven while off");
  a_irq_enabled: assert property (IRQ_OUT |-> en_r != 0 || $past(en_r) != 0) else $error("irq masked");
  c_err: cover property (PSLVERR_OUT);
  c_irq: cover property ($rose(IRQ_OUT));
  c_oe: cover property ($rose(COMPARE_OE_A_OUT));
endmodule // tmw_chk
bind tmw_timer8 tmw_chk u_chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .CE_IN(CE_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .IRQ_OUT(IRQ_OUT),
  .EXT_CLK_PIN_IN(EXT_CLK_PIN_IN), .COMPARE_OUT_A_OUT(COMPARE_OUT_A_OUT), .COMPARE_OE_A_OUT(COMPARE_OE_A_OUT),
  .COMPARE_OUT_B_OUT(COMPARE_OUT_B_OUT), .COMPARE_OE_B_OUT(COMPARE_OE_B_OUT));

// >>> dv/timer8_waveform_control_tb_top.sv
`timescale 1ns/1ps
module timer8_waveform_control_tb_top;
  import tmw_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, ext = 0, e, ce = 1;
  logic prdy, perr, oa, oea, ob, oeb, irq, ea;
  logic [11:0] pa = 0;
  logic [31:0] pd = 0, prd, q, t, lf = 32'h0001270d;
  logic [7:0] c;
  logic [1:0] fc [4] = '{2'd3, 2'd1, 2'd1, 2'd2};
  int n_fail = 0, compares = 0, h, x;
  always #5 clk = ~clk;
  tmw_timer8 dut (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pd), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
    .PSLVERR_OUT(perr), .EXT_CLK_PIN_IN(ext), .COMPARE_OUT_A_OUT(oa), .COMPARE_OE_A_OUT(oea),
    .COMPARE_OUT_B_OUT(ob), .COMPARE_OE_B_OUT(oeb), .IRQ_OUT(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected level after one compare action
  function automatic logic act(input logic [1:0] k, input logic cur);
    return (k == 2'b01) ? !cur : k[0];
  endfunction
  // Random activity on the external pin
  always @(posedge clk) begin
    lf <= lfsr(lf);
    ext <= lf[7];
  end
  task automatic close_out;
    $display("compares %0d fails %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] w);
    compares++;
    if (g !== w) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, g, w);
    end
  endtask
  task automatic rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    compares++;
    if (^g === 1'bx || g < lo || g > hi) begin
      n_fail++;
      $display("BAD %0t got %0d outside %0d..%0d", $time, g, lo, hi);
    end
  endtask
  // One APB transfer, waits for ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    {psel, pen, pwr, pa, pd} <= {1'b1, 1'b0, w, a, 24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      close_out();
    end
  endtask
  task automatic wait_irq;
    int n;
    for (n = 0; irq !== 1'b1 && n < 1000; n++) @(posedge clk);
    if (n >= 1000) begin
      n_fail++;
      close_out();
    end
  endtask
  task automatic highs(input int cyc);
    h = 0;
    repeat (cyc) begin
      @(posedge clk);
      h += int'(oa === 1'b1);
    end
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'({oea, oeb, irq}), 0);
    apb(0, TMW_OFS_CTRL_A, 0); chk(q, 0);
    apb(0, TMW_OFS_CTRL_B, 0); chk(q, 0);
    apb(1, TMW_OFS_CTRL_A, 8'hff); apb(0, TMW_OFS_CTRL_A, 0); chk(q, 32'hf3);
    apb(1, TMW_OFS_CTRL_B, 8'hc8); apb(0, TMW_OFS_CTRL_B, 0); chk(q, 32'h08);
    apb(1, TMW_OFS_CTRL_B, 0);
    apb(0, 12'h024, 0); chk({q[30:0], e}, 1);
    for (int i = 0; i < 8; i++) begin
      apb(1, TMW_OFS_PIN_DIR, {6'h0, i[2], i[2]});
      apb(1, TMW_OFS_CTRL_A, {i[1:0], i[1:0], 4'h0});
      repeat (2) @(posedge clk);
      chk(32'({oea, oeb}), {30'h0, {2{i[2] && i[1:0] != 0}}});
    end
    ea = 1'b0;
    foreach (fc[i]) begin
      apb(1, TMW_OFS_CTRL_A, {fc[i], fc[i], 4'h0});
      apb(1, TMW_OFS_CTRL_B, 8'hc0);
      ea = act(fc[i], ea);
      repeat (2) @(posedge clk);
      chk(32'({oa, ob}), 32'({ea, ea}));
    end
    apb(0, TMW_OFS_IRQ_STAT, 0); chk(q, 0);
    apb(1, TMW_OFS_CTRL_A, 0); apb(1, TMW_OFS_IRQ_EN, 1); apb(1, TMW_OFS_COUNT, 8'hf0);
    apb(1, TMW_OFS_CTRL_B, 1); wait_irq(); apb(1, TMW_OFS_CTRL_B, 0);
    apb(0, TMW_OFS_IRQ_STAT, 0); chk(32'(q[0]), 1);
    apb(1, TMW_OFS_IRQ_EN, 0); repeat (2) @(posedge clk); chk(32'(irq), 0);
    apb(1, TMW_OFS_IRQ_CLR, 7); apb(0, TMW_OFS_IRQ_STAT, 0); chk(q, 0);
    apb(1, TMW_OFS_COUNT, 0); apb(1, TMW_OFS_CTRL_B, 2); repeat (80) @(posedge clk);
    apb(1, TMW_OFS_CTRL_B, 0); apb(0, TMW_OFS_COUNT, 0); rng(q, 10, 11);
    t = q; repeat (20) @(posedge clk); apb(0, TMW_OFS_COUNT, 0); chk(q, t);
    // Enable low freezes a running count: only the three bus edges tick
    apb(1, TMW_OFS_CTRL_B, 1); ce <= 1'b0; repeat (20) @(posedge clk); ce <= 1'b1;
    apb(1, TMW_OFS_CTRL_B, 0); apb(0, TMW_OFS_COUNT, 0); chk(q, t + 32'd3);
    c = 8'h10 + 8'(lf[3:0]);
    apb(1, TMW_OFS_CMP_A, c); apb(1, TMW_OFS_COUNT, 0); apb(1, TMW_OFS_IRQ_EN, 2);
    apb(1, TMW_OFS_CTRL_A, 8'h02); apb(1, TMW_OFS_CTRL_B, 1); wait_irq(); apb(1, TMW_OFS_CTRL_B, 0);
    apb(0, TMW_OFS_COUNT, 0); rng(q, 0, 32'(c));
    apb(0, TMW_OFS_IRQ_STAT, 0); chk(32'(q[1:0]), 2);
    apb(1, TMW_OFS_IRQ_EN, 0);
    for (int m = 3; m > 0; m -= 2) begin
      c = 8'h20 + 8'(lf[6:0]);
      x = (m == 3) ? (int'(c) + 1) * 1020 / 256 : int'(c) * 1020 / 255;
      apb(1, TMW_OFS_CMP_A, c); apb(1, TMW_OFS_CTRL_A, {6'h20, m[1:0]}); apb(1, TMW_OFS_CTRL_B, 1);
      repeat (600) @(posedge clk);
      highs(1020); rng(h, x - 8, x + 8);
    end
    apb(1, TMW_OFS_CTRL_A, 8'h83); apb(1, TMW_OFS_CMP_A, 8'hff); repeat (600) @(posedge clk);
    highs(256); chk(h, 256);
    apb(1, TMW_OFS_CTRL_A, 8'h81); repeat (600) @(posedge clk);
    highs(510); chk(h, 510);
    close_out();
  end
endmodule // timer8_waveform_control_tb_top
